//--- rtl/progressive_scan_pkg.sv
/*
 Constants, encodings and types shared by the progressive scan coefficient control block.
 Assumes a single 50 MHz clock domain and 16-bit signed DCT coefficients in zig-zag order.
*/
// Notes on behaviour
// - A scan may use at most four entropy conditioning tables.
// - Spectral selection splits coefficients into bands, each band in its own scan.
// - Coefficients are divided by a power of two; decoder multiplies back.
// - Each later scan of a band adds exactly one bit of precision.
// - Full progression nests spectral selection in approximation; selection alone is allowed.
// - Only the portion chosen by band and shift parameters is coded.
// - A band is its start and end zig-zag index; one band per scan.
// - DC and AC coefficients never share a scan.
// - Only DC scans interleave components; AC scans carry one component.
// - Each component's first DC scan precedes any of its AC scans.
// - Current shift is the point transform; prior shift sits in high four bits.
// - DC codes whole shifted values first, later only the least significant bit.
// - AC codes shifted values first, later refines previously coded coefficients.
// - Huffman DC refinement bits go raw into the stream.
// - Huffman first-pass AC scans add end-of-band run symbols.
// - Buffering all transformed coefficients before the scans is recommended.
// - End-of-band runs above 32767 split into maximum runs plus remainder.
// - Run counter clears at interval start; pending run flushed at interval end.
// - Arithmetic DC refinement bits use estimate one half, more probable symbol zero.
package progressive_scan_pkg;
  localparam int          COEF_W        = 16;
  localparam int          INDEX_W       = 6;
  localparam int          SHIFT_W       = 4;
  localparam int          RUN_W         = 15;
  localparam int          ZRUN_W        = 6;
  localparam int          COMP_N        = 4;
  localparam int          TABLE_W       = 3;
  localparam int          PRIOR_MSB     = 7;
  localparam int          PRIOR_LSB     = 4;
  localparam int          CURRENT_MSB   = 3;
  localparam int          CURRENT_LSB   = 0;
  localparam logic [2:0]  MAX_TABLES    = 3'h4;
  localparam logic [5:0]  DC_INDEX      = 6'h00;
  localparam logic [14:0] EOB_RUN_MAX   = 15'h7FFF;
  localparam logic [15:0] EOB_SINGLE    = 16'h0001;
  localparam logic [15:0] DC_REFINE_QE  = 16'h5A1D;
  localparam logic        DC_REFINE_MPS = 1'b0;

  typedef enum logic [2:0] {
    SYM_VALUE,
    SYM_DC_RAW,
    SYM_DC_DECISION,
    SYM_NEW,
    SYM_REFINE,
    SYM_END_BAND
  } sym_kind_e;

  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_DC_FIRST,
    MODE_DC_REFINE,
    MODE_AC_FIRST,
    MODE_AC_REFINE
  } scan_mode_e;
endpackage

//--- rtl/point_shift.sv
/*
 Point transform of one coefficient by a power of two.
 Assumes a shift count already validated by the scan control.
*/
`timescale 1ns/10ps
`default_nettype none
module point_shift (
  input  wire logic signed [15:0] value_in,
  input  wire logic [3:0]         shift_in,
  input  wire logic               dc_in,
  output logic signed [15:0]      shifted_out,
  output logic [15:0]             magnitude_out,
  output logic                    negative_out
);
  logic [15:0] mag;
  logic [15:0] mag_sh;

  always_comb begin
    negative_out  = value_in[15];
    mag           = value_in[15] ? 16'(-value_in) : value_in;
    mag_sh        = mag >> shift_in;
    magnitude_out = mag_sh;
    // DC uses an arithmetic shift, AC divides the magnitude and keeps the sign
    if (dc_in) begin
      shifted_out = value_in >>> shift_in;
    end else begin
      shifted_out = negative_out ? 16'(-mag_sh) : mag_sh;
    end
  end
endmodule // point_shift
`default_nettype wire

//--- rtl/progressive_scan_coeff_control.sv
/*
 Scan-level control for progressive coefficient coding: selects coefficients and bit planes,
 classifies symbols and keeps the end-of-band run count.
 Assumes coefficients arrive in zig-zag order, one per taken cycle, from a frame buffer.
*/
`timescale 1ns/10ps
`default_nettype none
module progressive_scan_coeff_control (
  input  wire logic                                CLK_IN,
  input  wire logic                                ARST_N_IN,
  input  wire logic                                FRAME_START_IN,
  input  wire logic                                SCAN_START_IN,
  input  wire logic [5:0]                          BAND_START_IN,
  input  wire logic [5:0]                          BAND_END_IN,
  input  wire logic [7:0]                          APPROX_POS_IN,
  input  wire logic [3:0]                          SCAN_COMP_MASK_IN,
  input  wire logic [2:0]                          TABLE_COUNT_IN,
  input  wire logic                                ARITH_MODE_IN,
  input  wire logic                                SPECTRAL_ONLY_IN,
  input  wire logic                                COEF_VALID_IN,
  input  wire logic signed [15:0]                  COEF_IN,
  input  wire logic [5:0]                          COEF_INDEX_IN,
  input  wire logic                                INTERVAL_END_IN,
  input  wire logic                                SCAN_END_IN,
  output logic                                     COEF_READY_OUT,
  output logic                                     SCAN_ACTIVE_OUT,
  output logic                                     CONFIG_ERR_OUT,
  output logic                                     SYM_VALID_OUT,
  output var progressive_scan_pkg::sym_kind_e      SYM_KIND_OUT,
  output logic [15:0]                              SYM_VALUE_OUT,
  output logic [5:0]                               SYM_ZERO_RUN_OUT,
  output logic [15:0]                              SYM_QE_OUT,
  output logic                                     SYM_MPS_OUT
);
  typedef struct packed {
    progressive_scan_pkg::scan_mode_e mode;
    logic                             active;
    logic                             err;
    logic                             arith;
    logic [3:0]                       dc_done;
    logic [3:0]                       comp_mask;
    logic [5:0]                       band_start;
    logic [5:0]                       band_end;
    logic [3:0]                       cur_shift;
    logic [5:0]                       zero_run;
    logic [14:0]                      eob_run;
    logic                             hold_valid;
    progressive_scan_pkg::sym_kind_e  hold_kind;
    logic [15:0]                      hold_value;
    logic [5:0]                       hold_run;
    logic                             ready;
    logic                             sym_valid;
    progressive_scan_pkg::sym_kind_e  sym_kind;
    logic [15:0]                      sym_value;
    logic [5:0]                       sym_run;
    logic [15:0]                      sym_qe;
    logic                             sym_mps;
  } state_s;

  state_s                          st;
  state_s                          next_st;
  logic signed [15:0]              shifted;
  logic [15:0]                     magnitude;
  logic                            negative;
  logic                            take;
  logic                            in_band;
  logic                            block_end;
  logic                            dc_mode;
  logic [3:0]                      prior;
  logic [3:0]                      cur;
  logic                            scan_is_dc;
  logic                            one_comp;

  assign prior      = APPROX_POS_IN[progressive_scan_pkg::PRIOR_MSB:progressive_scan_pkg::PRIOR_LSB];
  assign cur        = APPROX_POS_IN[progressive_scan_pkg::CURRENT_MSB:progressive_scan_pkg::CURRENT_LSB];
  assign scan_is_dc = BAND_START_IN == progressive_scan_pkg::DC_INDEX;
  assign one_comp   = SCAN_COMP_MASK_IN != 4'h0 && (SCAN_COMP_MASK_IN & (SCAN_COMP_MASK_IN - 4'h1)) == 4'h0;
  assign take       = COEF_VALID_IN && st.ready && st.active;
  assign in_band    = COEF_INDEX_IN >= st.band_start && COEF_INDEX_IN <= st.band_end;
  assign block_end  = COEF_INDEX_IN == st.band_end;
  assign dc_mode    = st.mode == progressive_scan_pkg::MODE_DC_FIRST
                   || st.mode == progressive_scan_pkg::MODE_DC_REFINE;

  point_shift u_point_shift (
    .value_in      (COEF_IN),
    .shift_in      (st.cur_shift),
    .dc_in         (dc_mode),
    .shifted_out   (shifted),
    .magnitude_out (magnitude),
    .negative_out  (negative)
  );

  always_comb begin
    logic                            p_valid;
    progressive_scan_pkg::sym_kind_e p_kind;
    logic [15:0]                     p_value;
    logic [5:0]                      p_run;
    logic                            f_valid;
    logic [15:0]                     f_value;
    logic                            coded;
    logic                            bad;
    next_st           = st;
    p_valid           = 1'b0;
    p_kind            = progressive_scan_pkg::SYM_VALUE;
    p_value           = 16'h0000;
    p_run             = 6'h00;
    f_valid           = 1'b0;
    f_value           = 16'h0000;
    coded             = 1'b0;
    bad               = 1'b0;
    next_st.sym_valid = 1'b0;

    if (st.hold_valid) begin
      // Symbol displaced by an end-of-band flush goes out now; input is stalled meanwhile
      p_valid            = 1'b1;
      p_kind             = st.hold_kind;
      p_value            = st.hold_value;
      p_run              = st.hold_run;
      next_st.hold_valid = 1'b0;
    end else if (take && in_band) begin
      case (st.mode)
        progressive_scan_pkg::MODE_DC_FIRST: begin
          p_valid = 1'b1;
          p_value = shifted;
        end
        progressive_scan_pkg::MODE_DC_REFINE: begin
          p_valid = 1'b1;
          p_kind  = st.arith ? progressive_scan_pkg::SYM_DC_DECISION
                             : progressive_scan_pkg::SYM_DC_RAW;
          p_value = {15'h0000, shifted[0]};
        end
        progressive_scan_pkg::MODE_AC_FIRST: begin
          if (shifted != 16'h0000) begin
            p_valid          = 1'b1;
            p_value          = shifted;
            p_run            = st.zero_run;
            next_st.zero_run = 6'h00;
          end else begin
            next_st.zero_run = st.zero_run + 6'h01;
          end
        end
        progressive_scan_pkg::MODE_AC_REFINE: begin
          if (magnitude > 16'h0001) begin
            p_valid = 1'b1;
            p_kind  = progressive_scan_pkg::SYM_REFINE;
            p_value = {15'h0000, magnitude[0]};
          end else if (magnitude == 16'h0001) begin
            p_valid          = 1'b1;
            p_kind           = progressive_scan_pkg::SYM_NEW;
            p_value          = {15'h0000, !negative};
            p_run            = st.zero_run;
            next_st.zero_run = 6'h00;
          end else begin
            next_st.zero_run = st.zero_run + 6'h01;
          end
        end
        default: begin
        end
      endcase
      coded = p_valid && (p_kind == progressive_scan_pkg::SYM_VALUE
                       || p_kind == progressive_scan_pkg::SYM_NEW);
      if (!dc_mode) begin
        if (coded && st.eob_run != 15'h0000) begin
          f_valid         = 1'b1;
          f_value         = {1'b0, st.eob_run};
          next_st.eob_run = 15'h0000;
        end
        if (block_end) begin
          next_st.zero_run = 6'h00;
          if (!coded) begin
            if (st.arith) begin
              // Arithmetic coding ends each band on its own, runs never accumulate
              f_valid = 1'b1;
              f_value = progressive_scan_pkg::EOB_SINGLE;
            end else if (st.eob_run == progressive_scan_pkg::EOB_RUN_MAX - 15'h0001) begin
              f_valid         = 1'b1;
              f_value         = {1'b0, progressive_scan_pkg::EOB_RUN_MAX};
              next_st.eob_run = 15'h0000;
            end else begin
              next_st.eob_run = st.eob_run + 15'h0001;
            end
          end
        end
      end
    end else if (!COEF_VALID_IN && st.ready && (INTERVAL_END_IN || SCAN_END_IN)) begin
      if (st.eob_run != 15'h0000) begin
        f_valid = 1'b1;
        f_value = {1'b0, st.eob_run};
      end
      next_st.eob_run  = 15'h0000;
      next_st.zero_run = 6'h00;
      if (SCAN_END_IN) begin
        next_st.active = 1'b0;
        next_st.mode   = progressive_scan_pkg::MODE_IDLE;
        if (st.mode == progressive_scan_pkg::MODE_DC_FIRST) begin
          next_st.dc_done = st.dc_done | st.comp_mask;
        end
      end
    end

    if (f_valid) begin
      next_st.sym_valid  = 1'b1;
      next_st.sym_kind   = progressive_scan_pkg::SYM_END_BAND;
      next_st.sym_value  = f_value;
      next_st.sym_run    = 6'h00;
      next_st.hold_valid = p_valid;
      next_st.hold_kind  = p_kind;
      next_st.hold_value = p_value;
      next_st.hold_run   = p_run;
    end else if (p_valid) begin
      next_st.sym_valid = 1'b1;
      next_st.sym_kind  = p_kind;
      next_st.sym_value = p_value;
      next_st.sym_run   = p_run;
    end
    if (next_st.sym_valid && next_st.sym_kind == progressive_scan_pkg::SYM_DC_DECISION) begin
      next_st.sym_qe  = progressive_scan_pkg::DC_REFINE_QE;
      next_st.sym_mps = progressive_scan_pkg::DC_REFINE_MPS;
    end else begin
      next_st.sym_qe  = 16'h0000;
      next_st.sym_mps = 1'b0;
    end

    if (FRAME_START_IN) begin
      next_st.dc_done = 4'h0;
    end
    if (SCAN_START_IN) begin
      bad = TABLE_COUNT_IN > progressive_scan_pkg::MAX_TABLES
         || BAND_START_IN > BAND_END_IN
         || (scan_is_dc && BAND_END_IN != progressive_scan_pkg::DC_INDEX)
         || SCAN_COMP_MASK_IN == 4'h0
         || (!scan_is_dc && !one_comp)
         || (!scan_is_dc && (SCAN_COMP_MASK_IN & ~st.dc_done) != 4'h0)
         || (prior != 4'h0 && prior != cur + 4'h1)
         || (SPECTRAL_ONLY_IN && (prior != 4'h0 || cur != 4'h0));
      next_st.err        = bad;
      next_st.active     = !bad;
      next_st.arith      = ARITH_MODE_IN;
      next_st.comp_mask  = SCAN_COMP_MASK_IN;
      next_st.band_start = BAND_START_IN;
      next_st.band_end   = BAND_END_IN;
      next_st.cur_shift  = cur;
      next_st.zero_run   = 6'h00;
      next_st.eob_run    = 15'h0000;
      if (bad) begin
        next_st.mode = progressive_scan_pkg::MODE_IDLE;
      end else if (scan_is_dc) begin
        next_st.mode = prior == 4'h0 ? progressive_scan_pkg::MODE_DC_FIRST
                                     : progressive_scan_pkg::MODE_DC_REFINE;
      end else begin
        next_st.mode = prior == 4'h0 ? progressive_scan_pkg::MODE_AC_FIRST
                                     : progressive_scan_pkg::MODE_AC_REFINE;
      end
    end
    next_st.ready = !next_st.hold_valid;
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st       <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Coefficients are expected from a whole-frame buffer so any band order is possible
  assign COEF_READY_OUT   = st.ready;
  assign SCAN_ACTIVE_OUT  = st.active;
  assign CONFIG_ERR_OUT   = st.err;
  assign SYM_VALID_OUT    = st.sym_valid;
  assign SYM_KIND_OUT     = st.sym_kind;
  assign SYM_VALUE_OUT    = st.sym_value;
  assign SYM_ZERO_RUN_OUT = st.sym_run;
  assign SYM_QE_OUT       = st.sym_qe;
  assign SYM_MPS_OUT      = st.sym_mps;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  table_limit_a: assert property (
    SCAN_START_IN && TABLE_COUNT_IN > progressive_scan_pkg::MAX_TABLES
    |=> CONFIG_ERR_OUT && !SCAN_ACTIVE_OUT)
    else $error("too many tables accepted");

  dc_ac_mix_a: assert property (
    SCAN_START_IN && scan_is_dc && BAND_END_IN != 6'h00 |=> CONFIG_ERR_OUT)
    else $error("mixed DC and AC scan accepted");

  ac_single_comp_a: assert property (
    SCAN_START_IN && !scan_is_dc && !one_comp |=> CONFIG_ERR_OUT && !SCAN_ACTIVE_OUT)
    else $error("interleaved AC scan accepted");

  dc_first_order_a: assert property (
    SCAN_START_IN && !scan_is_dc && (SCAN_COMP_MASK_IN & ~st.dc_done) != 4'h0
    |=> CONFIG_ERR_OUT)
    else $error("AC scan before first DC scan accepted");

  one_bit_step_a: assert property (
    SCAN_START_IN && APPROX_POS_IN == 8'h31 && BAND_START_IN <= BAND_END_IN
    && TABLE_COUNT_IN <= progressive_scan_pkg::MAX_TABLES && one_comp
    && (scan_is_dc ? BAND_END_IN == 6'h00 : (SCAN_COMP_MASK_IN & ~st.dc_done) == 4'h0)
    && !SPECTRAL_ONLY_IN |=> CONFIG_ERR_OUT)
    else $error("refinement of more than one bit accepted");

  out_of_band_a: assert property (
    take && !in_band && !SCAN_START_IN |=> !SYM_VALID_OUT)
    else $error("coefficient outside band coded");

  eob_cap_a: assert property (
    SYM_VALID_OUT && SYM_KIND_OUT == progressive_scan_pkg::SYM_END_BAND
    |-> SYM_VALUE_OUT != 16'h0000 && SYM_VALUE_OUT <= 16'h7FFF)
    else $error("end-of-band run out of range");

  eob_wrap_a: assert property (
    take && in_band && block_end && !st.arith && st.mode == progressive_scan_pkg::MODE_AC_FIRST
    && shifted == 16'h0000 && st.eob_run == 15'h7FFE && !SCAN_START_IN
    |=> SYM_VALID_OUT && SYM_VALUE_OUT == 16'h7FFF && st.eob_run == 15'h0000)
    else $error("maximum run not emitted");

  interval_flush_a: assert property (
    !COEF_VALID_IN && st.ready && INTERVAL_END_IN && st.eob_run != 15'h0000 && !SCAN_START_IN
    |=> SYM_VALID_OUT && SYM_KIND_OUT == progressive_scan_pkg::SYM_END_BAND
    && SYM_VALUE_OUT == {1'b0, $past(st.eob_run)} && st.eob_run == 15'h0000)
    else $error("pending run not flushed at interval end");

  dc_raw_bit_a: assert property (
    take && in_band && st.mode == progressive_scan_pkg::MODE_DC_REFINE && !st.arith
    |=> SYM_VALID_OUT && SYM_KIND_OUT == progressive_scan_pkg::SYM_DC_RAW
    && SYM_VALUE_OUT[15:1] == 15'h0000)
    else $error("DC refinement bit not raw");

  dc_decision_a: assert property (
    SYM_VALID_OUT && SYM_KIND_OUT == progressive_scan_pkg::SYM_DC_DECISION
    |-> SYM_QE_OUT == 16'h5A1D && !SYM_MPS_OUT)
    else $error("DC decision estimate wrong");

  hold_release_a: assert property (
    SYM_VALID_OUT && !COEF_READY_OUT |=> SYM_VALID_OUT && COEF_READY_OUT)
    else $error("held symbol not released");
endmodule // progressive_scan_coeff_control
`default_nettype wire

//--- tb/scan_sym_sink.sv
/*
 Decoder-side partner: queues every coded symbol for the bench.
 Assumes the registered symbol ports of the scan control block.
*/
`timescale 1ns/10ps
`default_nettype none
module scan_sym_sink (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        sym_valid_in,
  input  wire logic [2:0]  kind_in,
  input  wire logic [15:0] value_in,
  input  wire logic [5:0]  zrun_in,
  input  wire logic [15:0] qe_in,
  input  wire logic        mps_in,
  output int               bad_out
);
  logic [24:0] q[$];
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q.delete();
      bad_out <= 0;
    end else if (sym_valid_in) begin
      q.push_back({kind_in, value_in, zrun_in});
      // A decision decodes only with the fixed half estimate
      if (kind_in == progressive_scan_pkg::SYM_DC_DECISION &&
          {qe_in, mps_in} !== {progressive_scan_pkg::DC_REFINE_QE, 1'b0}) begin
        bad_out <= bad_out + 1;
      end
    end
  end
endmodule // scan_sym_sink
`default_nettype wire

//--- tb/tb.sv
/*
 Testbench for the progressive scan coefficient control.
 Assumes the design and scan_sym_sink are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic CLK_IN, ARST_N_IN, FRAME_START_IN, SCAN_START_IN, ARITH_MODE_IN, SPECTRAL_ONLY_IN;
  logic COEF_VALID_IN, INTERVAL_END_IN, SCAN_END_IN;
  logic COEF_READY_OUT, SCAN_ACTIVE_OUT, CONFIG_ERR_OUT, SYM_VALID_OUT, SYM_MPS_OUT;
  logic [5:0] BAND_START_IN, BAND_END_IN, COEF_INDEX_IN, SYM_ZERO_RUN_OUT;
  logic [7:0] APPROX_POS_IN;
  logic [3:0] SCAN_COMP_MASK_IN;
  logic [2:0] TABLE_COUNT_IN;
  logic signed [15:0] COEF_IN;
  logic [15:0] SYM_VALUE_OUT, SYM_QE_OUT;
  progressive_scan_pkg::sym_kind_e SYM_KIND_OUT;
  logic [24:0] s;
  int failures, total_checks, cycles;
  progressive_scan_coeff_control i_dut (.CLK_IN, .ARST_N_IN, .FRAME_START_IN, .SCAN_START_IN,
    .BAND_START_IN, .BAND_END_IN, .APPROX_POS_IN, .SCAN_COMP_MASK_IN, .TABLE_COUNT_IN,
    .ARITH_MODE_IN, .SPECTRAL_ONLY_IN, .COEF_VALID_IN, .COEF_IN, .COEF_INDEX_IN,
    .INTERVAL_END_IN, .SCAN_END_IN, .COEF_READY_OUT, .SCAN_ACTIVE_OUT, .CONFIG_ERR_OUT,
    .SYM_VALID_OUT, .SYM_KIND_OUT, .SYM_VALUE_OUT, .SYM_ZERO_RUN_OUT, .SYM_QE_OUT,
    .SYM_MPS_OUT);
  scan_sym_sink i_sink (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .sym_valid_in(SYM_VALID_OUT),
    .kind_in(SYM_KIND_OUT), .value_in(SYM_VALUE_OUT), .zrun_in(SYM_ZERO_RUN_OUT),
    .qe_in(SYM_QE_OUT), .mps_in(SYM_MPS_OUT), .bad_out());
  initial begin
    CLK_IN = 1'b0;
    forever #10 CLK_IN = ~CLK_IN;
  end
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge CLK_IN);
    #1;
  endtask
  task automatic scan(input logic [5:0] bs, be, input logic [7:0] ap, input logic [3:0] m,
                      input logic [2:0] tc, input logic ar, sp, err);
    BAND_START_IN = bs;
    BAND_END_IN = be;
    APPROX_POS_IN = ap;
    SCAN_COMP_MASK_IN = m;
    TABLE_COUNT_IN = tc;
    ARITH_MODE_IN = ar;
    SPECTRAL_ONLY_IN = sp;
    SCAN_START_IN = 1'b1;
    step();
    SCAN_START_IN = 1'b0;
    chk({15'h0000, CONFIG_ERR_OUT}, {15'h0000, err});
    chk({15'h0000, SCAN_ACTIVE_OUT}, {15'h0000, ~err});
  endtask
  // Holds valid high across calls so back-to-back offers never glitch
  // Ready is read settled before the edge so the take decision matches the design's
  task automatic coef(input logic [5:0] i, input logic [15:0] v);
    int n;
    logic ok;
    n = 0;
    COEF_INDEX_IN = i;
    COEF_IN = v;
    COEF_VALID_IN = 1'b1;
    do begin
      ok = COEF_READY_OUT;
      step();
      n++;
    end while (ok !== 1'b1 && n < 8);
  endtask
  task automatic zeros;
    coef(6'h01, 16'h0000);
    coef(6'h02, 16'h0000);
    coef(6'h03, 16'h0000);
  endtask
  task automatic idle;
    COEF_VALID_IN = 1'b0;
    step();
  endtask
  task automatic pulse(input logic scan_end);
    SCAN_END_IN = scan_end;
    INTERVAL_END_IN = ~scan_end;
    step();
    SCAN_END_IN = 1'b0;
    INTERVAL_END_IN = 1'b0;
  endtask
  task automatic sym(input logic [2:0] k, input logic [15:0] v, input logic [5:0] z);
    int n;
    n = 0;
    while (i_sink.q.size() == 0 && n < 6) begin
      step();
      n++;
    end
    s = (i_sink.q.size() > 0) ? i_sink.q.pop_front() : 25'h1FFFFFF;
    chk({13'h0000, s[24:22]}, {13'h0000, k});
    chk(s[21:6], v);
    chk({10'h000, s[5:0]}, {10'h000, z});
  endtask
  always @(posedge CLK_IN) begin
    cycles++;
    if (cycles == 34000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {FRAME_START_IN, SCAN_START_IN, ARITH_MODE_IN, SPECTRAL_ONLY_IN, COEF_VALID_IN} = 5'h00;
    {INTERVAL_END_IN, SCAN_END_IN, BAND_START_IN, BAND_END_IN, COEF_INDEX_IN} = 20'h00000;
    {APPROX_POS_IN, SCAN_COMP_MASK_IN, TABLE_COUNT_IN, COEF_IN} = 31'h00000000;
    ARST_N_IN = 1'b0;
    repeat (5) @(posedge CLK_IN);
    #1;
    ARST_N_IN = 1'b1;
    chk({12'h000, COEF_READY_OUT, SCAN_ACTIVE_OUT, CONFIG_ERR_OUT, SYM_VALID_OUT}, 16'h0008);
    FRAME_START_IN = 1'b1;
    step();
    FRAME_START_IN = 1'b0;
    scan(6'h00, 6'h00, 8'h01, 4'h3, 3'h2, 1'b0, 1'b0, 1'b0);
    coef(6'h00, 16'h0008);
    coef(6'h00, 16'h0010);
    idle();
    sym(progressive_scan_pkg::SYM_VALUE, 16'h0004, 6'h00);
    sym(progressive_scan_pkg::SYM_VALUE, 16'h0008, 6'h00);
    pulse(1'b1);
    $display("test dc_first done");
    scan(6'h01, 6'h05, 8'h00, 4'h4, 3'h1, 1'b0, 1'b0, 1'b1);
    scan(6'h00, 6'h03, 8'h00, 4'h1, 3'h1, 1'b0, 1'b0, 1'b1);
    scan(6'h01, 6'h05, 8'h00, 4'h3, 3'h1, 1'b0, 1'b0, 1'b1);
    scan(6'h01, 6'h05, 8'h00, 4'h1, 3'h5, 1'b0, 1'b0, 1'b1);
    scan(6'h05, 6'h01, 8'h00, 4'h1, 3'h1, 1'b0, 1'b0, 1'b1);
    scan(6'h01, 6'h05, 8'h31, 4'h1, 3'h1, 1'b0, 1'b0, 1'b1);
    scan(6'h01, 6'h05, 8'h01, 4'h1, 3'h1, 1'b0, 1'b1, 1'b1);
    coef(6'h01, 16'h0005);
    idle();
    chk(16'(i_sink.q.size()), 16'h0000);
    scan(6'h01, 6'h05, 8'h00, 4'h1, 3'h1, 1'b0, 1'b1, 1'b0);
    $display("test config_err done");
    scan(6'h01, 6'h03, 8'h01, 4'h1, 3'h4, 1'b0, 1'b0, 1'b0);
    zeros();
    coef(6'h01, 16'h0000);
    coef(6'h02, 16'h000C);
    chk({15'h0000, COEF_READY_OUT}, 16'h0000);
    coef(6'h03, 16'h0000);
    idle();
    sym(progressive_scan_pkg::SYM_END_BAND, 16'h0001, 6'h00);
    sym(progressive_scan_pkg::SYM_VALUE, 16'h0006, 6'h01);
    zeros();
    idle();
    pulse(1'b0);
    sym(progressive_scan_pkg::SYM_END_BAND, 16'h0002, 6'h00);
    pulse(1'b1);
    idle();
    chk(16'(i_sink.q.size()), 16'h0000);
    scan(6'h01, 6'h03, 8'h00, 4'h1, 3'h1, 1'b1, 1'b0, 1'b0);
    zeros();
    coef(6'h04, 16'h0010);
    idle();
    sym(progressive_scan_pkg::SYM_END_BAND, 16'h0001, 6'h00);
    chk(16'(i_sink.q.size()), 16'h0000);
    pulse(1'b1);
    // One-coefficient band: every take ends a block, so the run reaches its cap quickly
    scan(6'h01, 6'h01, 8'h00, 4'h1, 3'h1, 1'b0, 1'b0, 1'b0);
    COEF_INDEX_IN = 6'h01;
    COEF_IN = 16'h0000;
    COEF_VALID_IN = 1'b1;
    repeat (32768) step();
    idle();
    sym(progressive_scan_pkg::SYM_END_BAND, 16'h7FFF, 6'h00);
    pulse(1'b1);
    sym(progressive_scan_pkg::SYM_END_BAND, 16'h0001, 6'h00);
    $display("test ac_first done");
    scan(6'h00, 6'h00, 8'h10, 4'h3, 3'h1, 1'b0, 1'b0, 1'b0);
    coef(6'h00, 16'h0005);
    coef(6'h00, 16'h0004);
    idle();
    sym(progressive_scan_pkg::SYM_DC_RAW, 16'h0001, 6'h00);
    sym(progressive_scan_pkg::SYM_DC_RAW, 16'h0000, 6'h00);
    pulse(1'b1);
    scan(6'h00, 6'h00, 8'h10, 4'h3, 3'h1, 1'b1, 1'b0, 1'b0);
    coef(6'h00, 16'h0003);
    idle();
    sym(progressive_scan_pkg::SYM_DC_DECISION, 16'h0001, 6'h00);
    chk(16'(i_sink.bad_out), 16'h0000);
    pulse(1'b1);
    $display("test dc_refine done");
    scan(6'h01, 6'h03, 8'h21, 4'h1, 3'h1, 1'b1, 1'b0, 1'b0);
    coef(6'h01, 16'hFFFE);
    coef(6'h02, 16'h0004);
    coef(6'h03, 16'h0006);
    idle();
    sym(progressive_scan_pkg::SYM_NEW, 16'h0000, 6'h00);
    sym(progressive_scan_pkg::SYM_REFINE, 16'h0000, 6'h00);
    sym(progressive_scan_pkg::SYM_END_BAND, 16'h0001, 6'h00);
    sym(progressive_scan_pkg::SYM_REFINE, 16'h0001, 6'h00);
    pulse(1'b1);
    $display("test ac_refine done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
